/* File: verilog/drive_words.sv */
`timescale 1ns/1ps
// control word, status word and parameter channel of the converter
module drive_words #(
	parameter logic [15:0] SW_VERSION = 16'h0100, // arbitrary value
	parameter logic [15:0] NOM_CURRENT = 16'h003c,
	parameter logic [15:0] CRIT_FREQ = 16'h0200,
	parameter int PASS_CYC = drive_pkg::PASS_CYCLES,
	parameter int LOAD_CYC = drive_pkg::LOAD_CYCLES
) (
	input wire logic mclk,
	input wire logic srst,
	// process data from the telegram
	input wire logic pd_valid,
	input wire logic [15:0] drive_control_word,
	input wire logic [15:0] second_process_word,
	output logic [15:0] drive_status_word,
	// parameter request and answer
	input wire logic req_valid,
	input wire logic [3:0] req_designator,
	input wire logic [10:0] req_param,
	input wire logic [7:0] req_index,
	input wire logic [15:0] req_value,
	output logic rsp_valid,
	output logic [3:0] rsp_designator,
	output logic [10:0] rsp_param,
	output logic [15:0] parameter_value_field,
	// drive measurements and state
	input wire logic [15:0] actual_freq,
	input wire logic [15:0] link_voltage,
	input wire logic [15:0] motor_current,
	input wire logic [15:0] input_power,
	input wire logic [15:0] motor_temp,
	input wire logic [15:0] heatsink_temp,
	input wire logic [15:0] load_pct,
	input wire logic drive_ready,
	input wire logic op_enabled,
	input wire logic drive_error,
	input wire logic accelerating,
	input wire logic decelerating,
	input wire logic switch_on_lock,
	input wire logic normal_op,
	input wire logic rotor_turning,
	input wire logic param_channel_en,
	input wire logic store_busy,
	// commands to the drive
	output logic run_cmd,
	output logic standby_en,
	output logic setpoint_sel,
	output logic [15:0] speed_setpoint,
	output logic error_clear,
	output logic save_request,
	output logic [2:0] switched_output,
	output logic error_relay,
	output logic normal_relay,
	output logic warning_relay
);
	import drive_pkg::*;

	typedef struct packed {
		logic [15:0] ctrl;
		logic [2:0][15:0] out_fn;
		logic [15:0] save_val;
		logic [15:0] setpoint;
		logic save_req;
		logic clr_req;
		logic temp_warn;
		logic [2:0] sw_out;
		logic [2:0] relay;
		logic rsp_valid;
		logic [3:0] rsp_des;
		logic [10:0] rsp_par;
		logic [15:0] rsp_val;
		logic [15:0] status;
	} words_t;

	words_t cur;
	words_t next_cur;
	logic run_up_err;
	logic speed_trip_err;
	logic high_load_err;
	logic overload_warn;
	logic [15:0] gated;
	logic [15:0] new_gated;
	logic fault_any;
	logic is_field;
	logic is_write;
	logic [1:0] fidx;

	// signed clamp of a 16-bit reading into its reporting range
	function automatic logic [15:0] clamp_s(
		input logic [15:0] v,
		input logic [15:0] lo,
		input logic [15:0] hi);
		if ($signed(v) < $signed(lo))
			return lo;
		else if ($signed(v) > $signed(hi))
			return hi;
		else
			return v;
	endfunction

	// masks the bits that need process data enable
	function automatic logic [15:0] gate_cw(input logic [15:0] cw);
		if (cw[CW_PD_EN])
			return cw;
		else
			return cw & ~CW_GATED;
	endfunction

	load_watch #(
		.PASS_CYC(PASS_CYC),
		.LOAD_CYC(LOAD_CYC)
	) u_watch (
		.mclk(mclk),
		.srst(srst),
		.accelerating(accelerating),
		.normal_op(normal_op),
		.actual_freq(actual_freq),
		.crit_freq(CRIT_FREQ),
		.load_pct(load_pct),
		.load_limit(OVL_DEF),
		.err_clear(cur.clr_req),
		.run_up_err(run_up_err),
		.speed_trip_err(speed_trip_err),
		.high_load_err(high_load_err),
		.overload_warn(overload_warn)
	);

	assign gated = gate_cw(cur.ctrl);
	assign new_gated = gate_cw(drive_control_word & CW_USED);
	assign fault_any = drive_error | run_up_err | speed_trip_err | high_load_err;
	assign is_field = (req_designator == QD_FREAD) || (req_designator == QD_FWR16);
	assign is_write = (req_designator == QD_WR16) || (req_designator == QD_FWR16);
	assign fidx = 2'(req_index - IDX_FIRST);

	// one registered copy of all state; answers come one cycle after a request
	always_comb
	begin
		next_cur = cur;
		next_cur.save_req = 1'b0;
		next_cur.clr_req = 1'b0;
		next_cur.rsp_valid = 1'b0;

		// telegram process data
		if (pd_valid)
		begin
			next_cur.ctrl = drive_control_word & CW_USED;
			// clear only on a fresh request and never while start is held
			if (new_gated[CW_CLR] && !gated[CW_CLR] && !new_gated[CW_START])
				next_cur.clr_req = 1'b1;
			if (new_gated[CW_SETPT])
				next_cur.setpoint = second_process_word;
		end

		// outputs and relays follow the registered word
		next_cur.sw_out[0] = gated[CW_OUT1] && cur.out_fn[0] == FN_FIELDBUS;
		next_cur.sw_out[1] = gated[CW_OUT2] && cur.out_fn[1] == FN_FIELDBUS;
		next_cur.sw_out[2] = gated[CW_OUT3] && cur.out_fn[2] == FN_FIELDBUS;
		next_cur.relay[0] = gated[CW_ERR_RLY];
		next_cur.relay[1] = gated[CW_NORM_RLY];
		next_cur.relay[2] = gated[CW_WARN_RLY];

		// motor temperature against its fixed threshold
		next_cur.temp_warn = $signed(motor_temp) > $signed(MWARN_DEF);

		// status word; unlisted bits stay zero
		next_cur.status = 16'h0000;
		next_cur.status[SW_READY] = drive_ready;
		next_cur.status[SW_OP_EN] = op_enabled;
		next_cur.status[SW_ERROR] = fault_any;
		next_cur.status[SW_ACCEL] = accelerating;
		next_cur.status[SW_DECEL] = decelerating;
		next_cur.status[SW_LOCK] = switch_on_lock;
		next_cur.status[SW_TEMP] = cur.temp_warn;
		next_cur.status[SW_PAR_EN] = param_channel_en;
		next_cur.status[SW_NORMAL] = normal_op;
		next_cur.status[SW_TURN] = rotor_turning;
		next_cur.status[SW_OVL] = overload_warn;
		next_cur.status[SW_WARN] = cur.temp_warn | overload_warn;
		next_cur.status[SW_PD_EN] = cur.ctrl[CW_PD_EN];

		// parameter channel
		if (req_valid)
		begin
			next_cur.rsp_valid = 1'b1;
			next_cur.rsp_par = req_param;
			next_cur.rsp_des = is_field ? RD_F16 : RD_V16;
			next_cur.rsp_val = 16'h0000;
			if (!is_write && req_designator != QD_READ && req_designator != QD_FREAD)
			begin
				next_cur.rsp_des = RD_FAIL;
				next_cur.rsp_val = ERR_TYPE;
			end
			else if (req_param == PN_OUTFN)
			begin
				if (!is_field || req_index < IDX_FIRST || req_index > IDX_LAST)
				begin
					next_cur.rsp_des = RD_FAIL;
					next_cur.rsp_val = ERR_INDEX;
				end
				else if (is_write && store_busy)
				begin
					next_cur.rsp_des = RD_FAIL;
					next_cur.rsp_val = ERR_BUSY;
				end
				else if (is_write)
				begin
					next_cur.out_fn[fidx] = req_value;
					next_cur.rsp_val = req_value;
				end
				else
					next_cur.rsp_val = cur.out_fn[fidx];
			end
			else if (is_field)
			begin
				next_cur.rsp_des = RD_FAIL;
				next_cur.rsp_val = ERR_INDEX;
			end
			else if (req_param == PN_SAVE)
			begin
				if (is_write && store_busy)
				begin
					next_cur.rsp_des = RD_FAIL;
					next_cur.rsp_val = ERR_BUSY;
				end
				else if (is_write)
				begin
					next_cur.save_val = req_value;
					next_cur.save_req = 1'b1;
					next_cur.rsp_val = req_value;
				end
				else
					next_cur.rsp_val = cur.save_val;
			end
			else
			begin
				unique case (req_param)
					PN_VERSION: next_cur.rsp_val = SW_VERSION;
					PN_FREQ: next_cur.rsp_val = actual_freq;
					PN_VOLT: next_cur.rsp_val = link_voltage > VOLT_MAX ? VOLT_MAX
						: link_voltage;
					PN_CURR: next_cur.rsp_val = motor_current;
					PN_POWER: next_cur.rsp_val = input_power;
					PN_MTEMP: next_cur.rsp_val = clamp_s(motor_temp, TEMP_MIN,
						MTEMP_MAX);
					PN_HTEMP: next_cur.rsp_val = clamp_s(heatsink_temp, TEMP_MIN,
						HTEMP_MAX);
					PN_MWARN: next_cur.rsp_val = MWARN_DEF;
					PN_NOMCUR: next_cur.rsp_val = NOM_CURRENT;
					PN_CRIT: next_cur.rsp_val = CRIT_FREQ;
					PN_OVL: next_cur.rsp_val = OVL_DEF;
					default:
					begin
						next_cur.rsp_des = RD_FAIL;
						next_cur.rsp_val = ERR_PARAM;
					end
				endcase
				// known read-only numbers refuse any write
				if (is_write && next_cur.rsp_des != RD_FAIL)
				begin
					next_cur.rsp_des = RD_FAIL;
					next_cur.rsp_val = ERR_RO;
				end
			end
		end
	end

	// all control state back to defaults on reset, like a supply loss
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			cur <= '0;
			cur.ctrl <= CW_RESET;
			cur.out_fn <= {3{OUTFN_RESET}};
			cur.save_val <= SAVE_RESET;
		end
		else
			cur <= next_cur;
	end

	// outputs from the state register; run, standby and setpoint select pass the enable mask
	assign drive_status_word = cur.status;
	assign rsp_valid = cur.rsp_valid;
	assign rsp_designator = cur.rsp_des;
	assign rsp_param = cur.rsp_par;
	assign parameter_value_field = cur.rsp_val;
	assign run_cmd = gated[CW_START];
	assign standby_en = gated[CW_STBY];
	assign setpoint_sel = gated[CW_SETPT];
	assign speed_setpoint = cur.setpoint;
	assign error_clear = cur.clr_req;
	assign save_request = cur.save_req;
	assign switched_output = cur.sw_out;
	assign error_relay = cur.relay[0];
	assign normal_relay = cur.relay[1];
	assign warning_relay = cur.relay[2];
endmodule

/* File: verilog/drive_pkg.sv */
// Behaviour
// - error clear ignored while start is set
// - process bits act only with bit ten; relay bits eleven and twelve act without it
// - bit six selects second word setpoint
// - bits five, fourteen, fifteen drive outputs
// - outputs follow bits only with code eighteen
// - bits eleven to thirteen drive relays
// - status word reports drive state bits
// - writing save parameter triggers nonvolatile save
// - parameter two returns software version
// - parameter four returns link voltage
// - parameter six returns input power
// - parameter seven returns motor temperature
// - parameter eleven returns heat sink temperature
// - motor over threshold raises temperature warning
// - parameter seventeen holds nominal motor current
// - reach critical frequency in time, then trip
// - sustained overload after run-up is error
// - read-only parameters refuse writes
// - failed request answers designator seven, error
// - control state returns to defaults on reset
package drive_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int PASS_TIME_MS = 1000;
	localparam int LOAD_TIME_MS = 10_000;
	localparam int PASS_CYCLES = PASS_TIME_MS * CYC_PER_MS;
	localparam int LOAD_CYCLES = LOAD_TIME_MS * CYC_PER_MS;

	// control word bit positions
	localparam int CW_START = 0;
	localparam int CW_OUT1 = 5;
	localparam int CW_SETPT = 6;
	localparam int CW_CLR = 7;
	localparam int CW_STBY = 8;
	localparam int CW_PD_EN = 10;
	localparam int CW_ERR_RLY = 11;
	localparam int CW_NORM_RLY = 12;
	localparam int CW_WARN_RLY = 13;
	localparam int CW_OUT2 = 14;
	localparam int CW_OUT3 = 15;
	localparam logic [15:0] CW_USED = 16'hfde1;
	localparam logic [15:0] CW_GATED = 16'he1e1;
	localparam logic [15:0] CW_RESET = 16'h0000;

	// status word bit positions
	localparam int SW_READY = 0;
	localparam int SW_OP_EN = 2;
	localparam int SW_ERROR = 3;
	localparam int SW_ACCEL = 4;
	localparam int SW_DECEL = 5;
	localparam int SW_LOCK = 6;
	localparam int SW_TEMP = 7;
	localparam int SW_PAR_EN = 9;
	localparam int SW_NORMAL = 10;
	localparam int SW_TURN = 11;
	localparam int SW_OVL = 13;
	localparam int SW_WARN = 14;
	localparam int SW_PD_EN = 15;

	// query and reply designators
	localparam logic [3:0] QD_READ = 4'h1;
	localparam logic [3:0] QD_WR16 = 4'h2;
	localparam logic [3:0] QD_FREAD = 4'h6;
	localparam logic [3:0] QD_FWR16 = 4'h7;
	localparam logic [3:0] RD_V16 = 4'h1;
	localparam logic [3:0] RD_F16 = 4'h4;
	localparam logic [3:0] RD_FAIL = 4'h7;

	// error numbers in the value field
	localparam logic [15:0] ERR_PARAM = 16'h0000;
	localparam logic [15:0] ERR_RO = 16'h0001;
	localparam logic [15:0] ERR_INDEX = 16'h0003;
	localparam logic [15:0] ERR_TYPE = 16'h0005;
	localparam logic [15:0] ERR_BUSY = 16'h0066;

	// parameter numbers
	localparam logic [10:0] PN_VERSION = 11'h002;
	localparam logic [10:0] PN_FREQ = 11'h003;
	localparam logic [10:0] PN_VOLT = 11'h004;
	localparam logic [10:0] PN_CURR = 11'h005;
	localparam logic [10:0] PN_POWER = 11'h006;
	localparam logic [10:0] PN_MTEMP = 11'h007;
	localparam logic [10:0] PN_SAVE = 11'h008;
	localparam logic [10:0] PN_HTEMP = 11'h00b;
	localparam logic [10:0] PN_MWARN = 11'h010;
	localparam logic [10:0] PN_NOMCUR = 11'h011;
	localparam logic [10:0] PN_CRIT = 11'h014;
	localparam logic [10:0] PN_OVL = 11'h015;
	localparam logic [10:0] PN_OUTFN = 11'h086;

	// output function field and value limits
	localparam logic [7:0] IDX_FIRST = 8'h01;
	localparam logic [7:0] IDX_LAST = 8'h03;
	localparam logic [15:0] FN_FIELDBUS = 16'h0012;
	localparam logic [15:0] OUTFN_RESET = 16'h0000;
	localparam logic [15:0] SAVE_RESET = 16'h0000;
	localparam logic [15:0] MWARN_DEF = 16'h0050;
	localparam logic [15:0] OVL_DEF = 16'h0064;
	localparam logic [15:0] VOLT_MAX = 16'h05dc;
	localparam logic [15:0] TEMP_MIN = 16'hfff6;
	localparam logic [15:0] MTEMP_MAX = 16'h0096;
	localparam logic [15:0] HTEMP_MAX = 16'h0064;
endpackage

/* File: verilog/load_watch.sv */
`timescale 1ns/1ps
// run-up and overload supervision of the rotor
module load_watch #(
	parameter int PASS_CYC = drive_pkg::PASS_CYCLES,
	parameter int LOAD_CYC = drive_pkg::LOAD_CYCLES
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic accelerating,
	input wire logic normal_op,
	input wire logic [15:0] actual_freq,
	input wire logic [15:0] crit_freq,
	input wire logic [15:0] load_pct,
	input wire logic [15:0] load_limit,
	input wire logic err_clear,
	output logic run_up_err,
	output logic speed_trip_err,
	output logic high_load_err,
	output logic overload_warn
);
	import drive_pkg::*;

	typedef struct packed {
		logic [31:0] pass_cnt;
		logic [31:0] load_cnt;
		logic reached;
		logic run_up_err;
		logic speed_trip_err;
		logic high_load_err;
		logic overload_warn;
	} watch_t;

	watch_t cur;
	watch_t next_cur;

	// errors hold until cleared; a new fault in the clear cycle wins
	always_comb
	begin
		next_cur = cur;
		next_cur.overload_warn = normal_op && (load_pct > load_limit);
		if (err_clear)
		begin
			next_cur.run_up_err = 1'b0;
			next_cur.speed_trip_err = 1'b0;
			next_cur.high_load_err = 1'b0;
		end
		if (actual_freq >= crit_freq)
			next_cur.reached = 1'b1;
		else if (!accelerating && !normal_op)
			next_cur.reached = 1'b0;
		// passing window only runs while accelerating below critical
		if (accelerating && !cur.reached)
		begin
			if (cur.pass_cnt >= 32'(PASS_CYC - 1))
				next_cur.run_up_err = 1'b1;
			else
				next_cur.pass_cnt = cur.pass_cnt + 32'd1;
		end
		else
			next_cur.pass_cnt = 32'd0;
		if (normal_op && cur.reached && actual_freq < crit_freq)
			next_cur.speed_trip_err = 1'b1;
		if (next_cur.overload_warn)
		begin
			if (cur.load_cnt >= 32'(LOAD_CYC - 1))
				next_cur.high_load_err = 1'b1;
			else
				next_cur.load_cnt = cur.load_cnt + 32'd1;
		end
		else
			next_cur.load_cnt = 32'd0;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign run_up_err = cur.run_up_err;
	assign speed_trip_err = cur.speed_trip_err;
	assign high_load_err = cur.high_load_err;
	assign overload_warn = cur.overload_warn;
endmodule

/* File: bench/drive_words_assertions.sv */
`timescale 1ns/1ps
// port-level checks of the converter word logic
module drive_words_assertions (
	input wire logic mclk,
	input wire logic srst,
	input wire logic pd_valid,
	input wire logic [15:0] drive_control_word,
	input wire logic [15:0] second_process_word,
	input wire logic [15:0] drive_status_word,
	input wire logic req_valid,
	input wire logic [3:0] req_designator,
	input wire logic [10:0] req_param,
	input wire logic store_busy,
	input wire logic drive_ready,
	input wire logic op_enabled,
	input wire logic param_channel_en,
	input wire logic normal_op,
	input wire logic rotor_turning,
	input wire logic rsp_valid,
	input wire logic [3:0] rsp_designator,
	input wire logic [15:0] parameter_value_field,
	input wire logic run_cmd,
	input wire logic standby_en,
	input wire logic setpoint_sel,
	input wire logic [15:0] speed_setpoint,
	input wire logic error_clear,
	input wire logic save_request,
	input wire logic error_relay,
	input wire logic normal_relay
);
	import drive_pkg::*;
	logic [4:0] level_in;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	// drive state levels that the status word mirrors one cycle later
	assign level_in = {drive_ready, op_enabled, param_channel_en, normal_op, rotor_turning};
	// a telegram taken and one more edge for the output stage
	sequence pd_taken;
		pd_valid ##1 1'b1;
	endsequence
	sequence save_write;
		req_valid && req_designator == QD_WR16 && req_param == PN_SAVE;
	endsequence
	answer_pulse_a: assert property (!$past(srst) |-> rsp_valid == $past(req_valid))
		else $error("answer pulse not one cycle after request");
	clear_blocked_a: assert property (pd_valid && drive_control_word[CW_START] |=> !error_clear)
		else $error("error clear passed while start set");
	gate_off_a: assert property (pd_valid && !drive_control_word[CW_PD_EN] |=>
		!(run_cmd || standby_en || setpoint_sel)) else $error("command acted without enable");
	setpoint_load_a: assert property (pd_valid && drive_control_word[CW_PD_EN] &&
		drive_control_word[CW_SETPT] |=> setpoint_sel && speed_setpoint == $past(second_process_word))
		else $error("setpoint not taken from second word");
	relay_follow_a: assert property (pd_taken |=>
		error_relay == $past(drive_control_word[CW_ERR_RLY], 2) &&
		normal_relay == $past(drive_control_word[CW_NORM_RLY], 2)) else $error("relay mismatch");
	process_flag_a: assert property (pd_taken |=>
		drive_status_word[SW_PD_EN] == $past(drive_control_word[CW_PD_EN], 2))
		else $error("process channel flag wrong");
	unused_zero_a: assert property (drive_status_word[1] == 1'b0 &&
		drive_status_word[8] == 1'b0 && drive_status_word[12] == 1'b0)
		else $error("unused status bit set");
	status_follow_a: assert property (!$past(srst) |->
		{drive_status_word[SW_READY], drive_status_word[SW_OP_EN], drive_status_word[SW_PAR_EN],
		drive_status_word[SW_NORMAL], drive_status_word[SW_TURN]} == $past(level_in))
		else $error("status levels wrong");
	save_pulse_a: assert property (save_write ##0 !store_busy |=>
		save_request && rsp_designator == RD_V16) else $error("save write not started");
	busy_refuse_a: assert property (save_write ##0 store_busy |=> !save_request &&
		rsp_designator == RD_FAIL && parameter_value_field == ERR_BUSY) else $error("busy not refused");
	ro_refuse_a: assert property (req_valid && req_designator == QD_WR16 &&
		req_param == PN_VOLT |=> rsp_designator == RD_FAIL && parameter_value_field == ERR_RO)
		else $error("read-only written");
endmodule

bind drive_words drive_words_assertions drive_words_assertions_inst (.*);

/* File: bench/fieldbus_master.sv */
`timescale 1ns/1ps
// master side: one telegram per call, lines scrambled once taken
module fieldbus_master (
	input wire logic mclk,
	output logic pd_valid,
	output logic [15:0] drive_control_word,
	output logic [15:0] second_process_word,
	output logic req_valid,
	output logic [3:0] req_designator,
	output logic [10:0] req_param,
	output logic [7:0] req_index,
	output logic [15:0] req_value,
	input wire logic rsp_valid,
	input wire logic [3:0] rsp_designator,
	input wire logic [15:0] parameter_value_field
);
	import drive_pkg::*;
	logic got_ok;
	logic [3:0] got_des;
	logic [15:0] got_val;
	// idle lines before the first telegram
	initial
	begin
		{pd_valid, drive_control_word, second_process_word} = '0;
		{req_valid, req_designator, req_param, req_index, req_value} = '0;
	end
	// stale words are inverted so a late sample cannot pass by luck
	task automatic send_pd(input logic [15:0] cw, input logic [15:0] sp);
		@(posedge mclk);
		#1;
		{pd_valid, drive_control_word, second_process_word} = {1'b1, cw, sp};
		@(posedge mclk);
		#1;
		{pd_valid, drive_control_word, second_process_word} = {1'b0, ~cw, ~sp};
	endtask
	// the answer is registered at the taking edge, so it is read just after it
	task automatic request(input logic [3:0] d, input logic [10:0] p, input logic [7:0] i,
		input logic [15:0] v);
		@(posedge mclk);
		#1;
		{req_valid, req_designator, req_param, req_index, req_value} = {1'b1, d, p, i, v};
		@(posedge mclk);
		#1;
		{req_valid, req_designator, req_param, req_index, req_value} = {1'b0, ~d, ~p, ~i, ~v};
		{got_ok, got_des, got_val} = {rsp_valid, rsp_designator, parameter_value_field};
	endtask
	// hand the three switched outputs to the fieldbus before driving them
	task automatic claim_outputs();
		for (int k = 1; k <= 3; k++)
			request(QD_FWR16, PN_OUTFN, 8'(k), FN_FIELDBUS);
	endtask
endmodule

/* File: bench/drive_words_tb.sv */
`timescale 1ns/1ps
// self-checking bench: reset values first, then parameter table, then hand-made word sequences
module drive_words_tb;
	import drive_pkg::*;
	typedef struct packed {
		logic [3:0] d;
		logic [10:0] p;
		logic [7:0] i;
		logic [3:0] ed;
		logic [15:0] ev;
	} row_t;
	localparam logic [15:0] VERSION = 16'h0a0b; // arbitrary value
	localparam logic [15:0] NOMC = 16'h003c;
	localparam logic [15:0] CRIT = 16'h0200;
	logic mclk, srst, pd_valid, req_valid, rsp_valid;
	logic [15:0] drive_control_word, second_process_word, drive_status_word;
	logic [15:0] req_value, parameter_value_field, speed_setpoint;
	logic [3:0] req_designator, rsp_designator;
	logic [10:0] req_param, rsp_param;
	logic [7:0] req_index;
	logic [15:0] actual_freq, link_voltage, motor_current, input_power;
	logic [15:0] motor_temp, heatsink_temp, load_pct;
	logic drive_ready, op_enabled, drive_error, accelerating, decelerating, switch_on_lock;
	logic normal_op, rotor_turning, param_channel_en, store_busy;
	logic run_cmd, standby_en, setpoint_sel, error_clear, save_request;
	logic error_relay, normal_relay, warning_relay;
	logic [2:0] switched_output;
	int mismatches = 0;
	int samples_checked = 0;
	row_t rows[14] = '{
		'{QD_READ, PN_VERSION, 8'h00, RD_V16, VERSION},
		'{QD_READ, PN_VOLT, 8'h00, RD_V16, VOLT_MAX},
		'{QD_READ, PN_POWER, 8'h00, RD_V16, 16'h1234},
		'{QD_READ, PN_MTEMP, 8'h00, RD_V16, TEMP_MIN},
		'{QD_READ, PN_HTEMP, 8'h00, RD_V16, HTEMP_MAX},
		'{QD_READ, PN_MWARN, 8'h00, RD_V16, MWARN_DEF},
		'{QD_READ, PN_NOMCUR, 8'h00, RD_V16, NOMC},
		'{QD_READ, PN_CRIT, 8'h00, RD_V16, CRIT},
		'{QD_READ, PN_OVL, 8'h00, RD_V16, OVL_DEF},
		'{QD_READ, PN_SAVE, 8'h00, RD_V16, SAVE_RESET},
		'{QD_WR16, PN_VOLT, 8'h00, RD_FAIL, ERR_RO},
		'{QD_READ, 11'h009, 8'h00, RD_FAIL, ERR_PARAM},
		'{4'h3, PN_SAVE, 8'h00, RD_FAIL, ERR_TYPE},
		'{QD_FREAD, PN_OUTFN, 8'h04, RD_FAIL, ERR_INDEX}
	};
	drive_words #(.SW_VERSION(VERSION), .NOM_CURRENT(NOMC), .CRIT_FREQ(CRIT), .PASS_CYC(20),
		.LOAD_CYC(30)) drive_words_inst (.*);
	fieldbus_master fieldbus_master_inst (.*);
	// 50 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// one parameter request and its full answer
	task automatic ask(input logic [3:0] d, input logic [10:0] p, input logic [7:0] i,
		input logic [15:0] v, input logic [3:0] ed, input logic [15:0] ev);
		fieldbus_master_inst.request(d, p, i, v);
		check({11'h0, fieldbus_master_inst.got_ok, fieldbus_master_inst.got_des}, {12'h001, ed});
		check(fieldbus_master_inst.got_val, ev);
		check({5'h0, rsp_param}, {5'h0, p});
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// the whole sequence needs under two hundred cycles
	initial
	begin
		#100000;
		mismatches++;
		wrap_up();
	end
	// main sequence
	initial
	begin
		srst = 1'b1;
		{actual_freq, link_voltage, motor_current, input_power} = 64'h0300_07d0_0050_1234;
		{motor_temp, heatsink_temp, load_pct} = 48'hffe0_0070_0010;
		{drive_ready, op_enabled, drive_error, accelerating, decelerating} = 5'b11000;
		{switch_on_lock, normal_op, rotor_turning, param_channel_en, store_busy} = 5'b00110;
		repeat (5) @(posedge mclk);
		#1;
		srst = 1'b0;
		check({5'h0, run_cmd, standby_en, setpoint_sel, error_clear, save_request, switched_output,
			error_relay, normal_relay, warning_relay}, 16'h0000);
		settle(2);
		check(drive_status_word, 16'h0a05);
		$display("reset test done");
		foreach (rows[n])
			ask(rows[n].d, rows[n].p, rows[n].i, 16'h0005, rows[n].ed, rows[n].ev);
		$display("table test done");
		// process bits without the enable must do nothing, error relay still follows, warning relay stays masked
		fieldbus_master_inst.send_pd(16'h6861, 16'h0111);
		check({13'h0, run_cmd, setpoint_sel, standby_en}, 16'h0000);
		check(speed_setpoint, 16'h0000);
		settle(1);
		check({12'h0, error_relay, warning_relay, drive_status_word[15], switched_output[0]}, 16'h0008);
		// outputs stay off until each index holds the fieldbus code
		fieldbus_master_inst.send_pd(16'hfd60, 16'h0123);
		check({13'h0, run_cmd, standby_en, setpoint_sel}, 16'h0003);
		check(speed_setpoint, 16'h0123);
		settle(1);
		check({9'h0, switched_output, error_relay, normal_relay, warning_relay,
			drive_status_word[15]}, 16'h000f);
		fieldbus_master_inst.claim_outputs();
		check({12'h0, fieldbus_master_inst.got_des}, {12'h0, RD_F16});
		ask(QD_FREAD, PN_OUTFN, 8'h02, 16'h0000, RD_F16, FN_FIELDBUS);
		fieldbus_master_inst.send_pd(16'hfd60, 16'h0123);
		settle(1);
		check({13'h0, switched_output}, 16'h0007);
		$display("output test done");
		// clear is refused while start is set, then pulses on a fresh request
		fieldbus_master_inst.send_pd(16'h0481, 16'h0000);
		check({14'h0, run_cmd, error_clear}, 16'h0002);
		fieldbus_master_inst.send_pd(16'h0400, 16'h0000);
		fieldbus_master_inst.send_pd(16'h0480, 16'h0000);
		check({14'h0, run_cmd, error_clear}, 16'h0001);
		$display("clear test done");
		// save command, its read-back and refusal during a store
		fieldbus_master_inst.request(QD_WR16, PN_SAVE, 8'h00, 16'h0005);
		check({11'h0, save_request, fieldbus_master_inst.got_des}, 16'h0011);
		ask(QD_READ, PN_SAVE, 8'h00, 16'h0000, RD_V16, 16'h0005);
		store_busy = 1'b1;
		ask(QD_WR16, PN_SAVE, 8'h00, 16'h0007, RD_FAIL, ERR_BUSY);
		store_busy = 1'b0;
		$display("save test done");
		// warnings first, then the high-load error after the load time
		{motor_temp, load_pct, normal_op} = {16'h0051, 16'h0065, 1'b1};
		settle(4);
		check(drive_status_word & 16'he488, 16'he480);
		settle(40);
		check(drive_status_word & 16'h0008, 16'h0008);
		$display("load test done");
		// clear the latched error, then run up too slowly past the window
		{actual_freq, load_pct, normal_op} = {16'h0100, 16'h0000, 1'b0};
		settle(2);
		fieldbus_master_inst.send_pd(16'h0400, 16'h0000);
		fieldbus_master_inst.send_pd(16'h0480, 16'h0000);
		settle(2);
		check(drive_status_word & 16'h0018, 16'h0000);
		accelerating = 1'b1;
		settle(15);
		check(drive_status_word & 16'h0018, 16'h0010);
		settle(10);
		check(drive_status_word & 16'h0018, 16'h0018);
		$display("run-up test done");
		wrap_up();
	end
endmodule
